// >>> logic/dum_core.sv
// Decision unit index and auxiliary register files with moves, pause and no-operation.

// The block takes one instruction word, split into two fields, whenever
// instr_valid and instr_ready are both high at a rising clock edge.
// A move copies its source onto the internal transfer bus at the take edge
// and writes the destination at the next edge. A move whose condition holds therefore costs
// one busy cycle, and the following word already sees the new contents.
// A pause count stalls issue for that many cycles after the word that
// carries it; with a move, the write cycle counts as the first of them.
// A no-operation occupies only its own cycle and leaves every register alone.
// The address processor port reads the index file through a register, and
// it always sees the contents as they stood before any write of that edge.
// Register files are flip-flops so that the read port never waits on a
// memory macro; the price is area, which is acceptable at this size.
`timescale 1ns/1ps
module dum_core
  import dum_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Instruction issue.
  input wire logic instr_valid,
  input wire logic [15:0] instr_field0,
  input wire logic [15:0] instr_field1,
  output logic instr_ready,
  // Condition and shared data bus second slot.
  input wire logic condition_bit,
  input wire logic [WIDTH-1:0] shared_data_bus_second,
  output logic shared_data_bus_drive,
  output logic error_flag,
  // Address processor read port.
  input wire logic [REG_NUM_W-1:0] map_index_sel,
  output logic [WIDTH-1:0] map_index_data
);

  // Index file shared with the address processor, and the private auxiliary file.
  logic [WIDTH-1:0] index_q [REG_COUNT];
  logic [WIDTH-1:0] index_d [REG_COUNT];
  logic [WIDTH-1:0] aux_q [REG_COUNT];
  logic [WIDTH-1:0] aux_d [REG_COUNT];
  // Move pipeline: the word carried from the read phase to the write phase.
  logic [WIDTH-1:0] internal_transfer_bus_q;
  logic [WIDTH-1:0] internal_transfer_bus_d;
  logic [REG_NUM_W-1:0] dest_q;
  logic [REG_NUM_W-1:0] dest_d;
  logic dest_aux_q;
  logic dest_aux_d;
  // Sequencer state and the remaining pause cycles.
  logic [PAUSE_W-1:0] pause_q;
  logic [PAUSE_W-1:0] pause_d;
  dum_state_t state_q;
  dum_state_t state_d;
  // Registered read port toward the address processor.
  logic [WIDTH-1:0] map_data_q;
  logic [WIDTH-1:0] map_data_d;

  logic [OPC_W-1:0] opc;
  logic [REG_NUM_W-1:0] src_num, dst_num;
  logic [PAUSE_W-1:0] pause_cnt;
  logic is_move, is_cond, src_aux, dst_aux, is_nop, is_store;

  // Decode: opcode in field one, register numbers in the low bits.
  always_comb begin
    opc = instr_field1[OPC_LSB +: OPC_W];
    src_num = instr_field0[REG_NUM_W-1:0];
    dst_num = instr_field1[REG_NUM_W-1:0];
    pause_cnt = instr_field0[PAUSE_LSB +: PAUSE_W];
    is_nop = (opc == OPC_NOP);
    is_store = (opc == OPC_STORE_X2_C);
    is_move = 1'b1;
    is_cond = opc[0];
    src_aux = 1'b0;
    dst_aux = 1'b0;
    // Only the eight move codes set is_move; any other code is a store, pause or no-operation.
    unique case (opc)
      OPC_MOVE_II, OPC_MOVE_II_C: begin
        src_aux = 1'b0;
        dst_aux = 1'b0;
      end
      OPC_MOVE_IX, OPC_MOVE_IX_C: begin
        src_aux = 1'b0;
        dst_aux = 1'b1;
      end
      OPC_MOVE_XI, OPC_MOVE_XI_C: begin
        src_aux = 1'b1;
        dst_aux = 1'b0;
      end
      OPC_MOVE_XX, OPC_MOVE_XX_C: begin
        src_aux = 1'b1;
        dst_aux = 1'b1;
      end
      default: is_move = 1'b0;
    endcase
  end

  // Sequencer: a move reads in the first phase and writes in the second; pauses stall.
  always_comb begin
    state_d = state_q;
    pause_d = pause_q;
    dest_d = dest_q;
    dest_aux_d = dest_aux_q;
    internal_transfer_bus_d = internal_transfer_bus_q;
    index_d = index_q;
    aux_d = aux_q;
    instr_ready = (state_q == DUM_IDLE);
    unique case (state_q)
      DUM_IDLE: begin
        if (instr_valid) begin
          if (is_move && (!is_cond || condition_bit)) begin
            internal_transfer_bus_d = src_aux ? aux_q[src_num] : index_q[src_num];
            dest_d = dst_num;
            dest_aux_d = dst_aux;
            pause_d = pause_cnt;
            state_d = DUM_WRITE;
          end else begin
            if (is_store && condition_bit) begin
              aux_d[dst_num] = shared_data_bus_second;
            end
            // A no-operation touches no register and takes its one cycle here.
            if (!is_nop && pause_cnt != '0) begin
              pause_d = pause_cnt;
              state_d = DUM_PAUSE;
            end
          end
        end
      end
      DUM_WRITE: begin
        // The destination file was chosen at the take edge and held since.
        if (dest_aux_q) begin
          aux_d[dest_q] = internal_transfer_bus_q;
        end else begin
          index_d[dest_q] = internal_transfer_bus_q;
        end
        // The write phase counts as one of the pause cycles.
        if (pause_q > 1) begin
          pause_d = pause_q - 1'b1;
          state_d = DUM_PAUSE;
        end else begin
          pause_d = '0;
          state_d = DUM_IDLE;
        end
      end
      DUM_PAUSE: begin
        if (pause_q <= 1) begin
          pause_d = '0;
          state_d = DUM_IDLE;
        end else begin
          pause_d = pause_q - 1'b1;
        end
      end
      default: state_d = DUM_IDLE;
    endcase
  end

  // Read port: the address processor sees the old contents, ahead of any write this edge.
  always_comb begin
    map_data_d = index_q[map_index_sel];
  end

  // Control registers of the sequencer and the move pipeline.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DUM_IDLE;
      pause_q <= '0;
      dest_q <= '0;
      dest_aux_q <= 1'b0;
      internal_transfer_bus_q <= '0;
    end else begin
      state_q <= state_d;
      pause_q <= pause_d;
      dest_q <= dest_d;
      dest_aux_q <= dest_aux_d;
      internal_transfer_bus_q <= internal_transfer_bus_d;
    end
  end

  // Register files; they reset to zero so that every run starts from known contents.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        index_q[i] <= REG_RESET[WIDTH-1:0];
        aux_q[i] <= REG_RESET[WIDTH-1:0];
      end
    end else begin
      index_q <= index_d;
      aux_q <= aux_d;
    end
  end

  // Read port register; it costs the address processor one cycle of latency.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      map_data_q <= '0;
    end else begin
      map_data_q <= map_data_d;
    end
  end

  // These instructions never raise an error nor drive the shared bus.
  // Both outputs are tied low on purpose, so that a wider processor built
  // around this block can merge them with its own bus and error logic.
  assign shared_data_bus_drive = 1'b0;
  assign error_flag = 1'b0;
  assign map_index_data = map_data_q;

endmodule

// >>> logic/dum_pkg.sv
// Package of constants for the decision unit register move block.
package dum_pkg;
  localparam int DATA_W = 16;
  localparam int REG_NUM_W = 7;
  localparam int REG_COUNT = 128;
  localparam int PAUSE_W = 3;
  localparam int PAUSE_LSB = 8;
  localparam int OPC_LSB = 7;
  localparam int OPC_W = 9;
  // Opcode values of field one bits 15..7.
  localparam logic [8:0] OPC_MOVE_II = 9'h00A;
  localparam logic [8:0] OPC_MOVE_II_C = 9'h00B;
  localparam logic [8:0] OPC_MOVE_IX = 9'h012;
  localparam logic [8:0] OPC_MOVE_IX_C = 9'h013;
  localparam logic [8:0] OPC_MOVE_XI = 9'h01A;
  localparam logic [8:0] OPC_MOVE_XI_C = 9'h01B;
  localparam logic [8:0] OPC_MOVE_XX = 9'h022;
  localparam logic [8:0] OPC_MOVE_XX_C = 9'h023;
  localparam logic [8:0] OPC_STORE_X2_C = 9'h01D;
  localparam logic [8:0] OPC_NOP = 9'h1FF;
  localparam logic [15:0] REG_RESET = 16'h0000;
  typedef enum logic [1:0] {
    DUM_IDLE = 2'b00,
    DUM_WRITE = 2'b01,
    DUM_PAUSE = 2'b10
  } dum_state_t;
endpackage

// >>> test/dum_core_asserts.sv
// Checker of stall, write and bus timing at the block ports.
`timescale 1ns/1ps
module dum_chk
  import dum_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Instruction issue.
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic condition_bit,
  input wire logic [15:0] instr_field0,
  input wire logic [15:0] instr_field1,
  // Flags.
  input wire logic shared_data_bus_drive,
  input wire logic error_flag,
  // Read port.
  input wire logic [6:0] map_index_sel,
  input wire logic [15:0] map_index_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic tk;
  logic [8:0] op;
  logic [2:0] d;
  // Decode of the taken word, so each property names its trigger plainly.
  assign tk = instr_valid && instr_ready;
  assign op = instr_field1[15:7];
  assign d = instr_field0[10:8];
  property p_nodrv; !shared_data_bus_drive; endproperty
  a_nodrv: assert property (p_nodrv) else $error("data bus driven");
  property p_noerr; !error_flag; endproperty
  a_noerr: assert property (p_noerr) else $error("error raised");
  property p_mv; tk && op == OPC_MOVE_II && d == 3'h0 |=> !instr_ready ##1 instr_ready; endproperty
  a_mv: assert property (p_mv) else $error("move busy time");
  property p_mvp; tk && op == OPC_MOVE_XX && d == 3'h3 |=> !instr_ready [*3] ##1 instr_ready; endproperty
  a_mvp: assert property (p_mvp) else $error("move with pause time");
  property p_pau; tk && op == 9'h000 && d == 3'h2 |=> !instr_ready [*2] ##1 instr_ready; endproperty
  a_pau: assert property (p_pau) else $error("pause time");
  property p_nop; tk && op == OPC_NOP |=> instr_ready; endproperty
  a_nop: assert property (p_nop) else $error("nop time");
  property p_st; tk && op == OPC_STORE_X2_C && d == 3'h0 |=> instr_ready; endproperty
  a_st: assert property (p_st) else $error("store stalled");
  // A refused move must leave the watched index register as it was.
  property p_cf; tk && op == OPC_MOVE_II_C && !condition_bit && map_index_sel == instr_field1[6:0]
    ##1 $stable(map_index_sel) [*2] |=> $stable(map_index_data); endproperty
  a_cf: assert property (p_cf) else $error("refused move wrote");
  c_nop: cover property (tk && op == OPC_NOP);
  c_st: cover property (tk && op == OPC_STORE_X2_C && condition_bit);
  c_mv: cover property (tk && op == OPC_MOVE_XI);
endmodule
bind dum_core dum_chk u_chk (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .condition_bit(condition_bit), .instr_field0(instr_field0),
  .instr_field1(instr_field1), .shared_data_bus_drive(shared_data_bus_drive),
  .error_flag(error_flag), .map_index_sel(map_index_sel), .map_index_data(map_index_data));

// >>> test/dum_map_model.sv
// Address processor model that reads the shared index file.
`timescale 1ns/1ps
module dum_map_model (
  // Select from the bench and select toward the block.
  input wire logic [6:0] req_sel,
  output logic [6:0] map_index_sel
);
  // Select only: this side has no write path into the index file.
  assign map_index_sel = req_sel;
endmodule

// >>> test/test_decision_unit_register_moves.sv
// Self-checking bench of the register move block.
`timescale 1ns/1ps
module test_decision_unit_register_moves;
  import dum_pkg::*;
  logic clock = '0, rst_n = '0, instr_valid = '0, condition_bit = '0, instr_ready, drv, err;
  logic [15:0] instr_field0 = '0, instr_field1 = '0, sd = '0, map_index_data;
  logic [6:0] req = '0, map_index_sel;
  int n_mismatch = 0, checks = 0;
  // Free running clock, 40 ns period.
  always #20 clock = ~clock;
  dum_core DUT (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_field0(instr_field0), .instr_field1(instr_field1), .instr_ready(instr_ready),
    .condition_bit(condition_bit), .shared_data_bus_second(sd), .shared_data_bus_drive(drv),
    .error_flag(err), .map_index_sel(map_index_sel), .map_index_data(map_index_data));
  dum_map_model u_map (.req_sel(req), .map_index_sel(map_index_sel));
  task chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Valid stays up after the take, so back-to-back words meet a busy block.
  task iss(input logic [8:0] op, input logic [6:0] s, t, input logic [2:0] d, input logic c,
    input logic [15:0] v);
    repeat (9) if (!instr_ready) @(negedge clock);
    instr_valid = 1'b1;
    instr_field0 = {5'h00, d, 1'b0, s};
    instr_field1 = {op, t};
    condition_bit = c;
    sd = v;
    req = t;
    @(negedge clock);
  endtask
  task mv(input logic [8:0] op, input logic [6:0] s, t, input logic c);
    iss(op, s, t, 3'h0, c, 16'hFFFF);
  endtask
  task rd(input logic [6:0] s, input logic [15:0] e);
    instr_valid = 1'b0;
    req = s;
    repeat (3) @(negedge clock);
    chk(map_index_data, e);
  endtask
  task stall(input logic [8:0] op, input logic [2:0] d, input logic [15:0] e);
    int n;
    iss(op, 7'h00, 7'h00, d, 1'b0, 16'h0000);
    instr_valid = 1'b0;
    for (n = 0; n < 9 && !instr_ready; n++) @(negedge clock);
    chk(16'(n), e);
  endtask
  // Conditional second-slot stores, made visible by moving them to the index file.
  task t_store;
    iss(OPC_STORE_X2_C, 7'h00, 7'h05, 3'h0, 1'b1, 16'h1234);
    iss(OPC_STORE_X2_C, 7'h00, 7'h06, 3'h0, 1'b0, 16'hBEEF);
    mv(OPC_MOVE_XI, 7'h05, 7'h01, 1'b0);
    mv(OPC_MOVE_XI, 7'h06, 7'h02, 1'b0);
    rd(7'h01, 16'h1234);
    rd(7'h02, 16'h0000);
  endtask
  // Unconditional moves of all four pairings; the target is read while written.
  task t_move;
    mv(OPC_MOVE_II, 7'h01, 7'h03, 1'b0);
    instr_valid = 1'b0;
    @(negedge clock);
    chk(map_index_data, 16'h0000);
    @(negedge clock);
    chk(map_index_data, 16'h1234);
    mv(OPC_MOVE_II, 7'h03, 7'h04, 1'b0);
    mv(OPC_MOVE_IX, 7'h04, 7'h07, 1'b0);
    mv(OPC_MOVE_XX, 7'h07, 7'h08, 1'b0);
    mv(OPC_MOVE_XI, 7'h08, 7'h7F, 1'b0);
    rd(7'h7F, 16'h1234);
  endtask
  // Conditional moves, first with the condition set and then with it clear.
  task t_cond;
    mv(OPC_MOVE_IX_C, 7'h01, 7'h0C, 1'b1);
    mv(OPC_MOVE_XX_C, 7'h0C, 7'h0D, 1'b1);
    mv(OPC_MOVE_XI_C, 7'h0D, 7'h0E, 1'b1);
    mv(OPC_MOVE_II_C, 7'h0E, 7'h0F, 1'b1);
    rd(7'h0F, 16'h1234);
    mv(OPC_MOVE_II_C, 7'h01, 7'h10, 1'b0);
    rd(7'h10, 16'h0000);
    mv(OPC_MOVE_XI_C, 7'h05, 7'h11, 1'b0);
    rd(7'h11, 16'h0000);
  endtask
  // Standalone pauses and a pause carried by a move.
  task t_pause;
    stall(9'h000, 3'h2, 16'h0002);
    stall(9'h000, 3'h7, 16'h0007);
    stall(OPC_MOVE_XX, 3'h3, 16'h0003);
  endtask
  // A no-operation takes only its own cycle; the shared bus and error stay quiet.
  task t_nop;
    stall(OPC_NOP, 3'h0, 16'h0000);
    rd(7'h01, 16'h1234);
    chk({14'h0000, drv, err}, 16'h0000);
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    t_store;
    t_move;
    t_cond;
    t_pause;
    t_nop;
    end_sim;
  end
  // Watchdog well beyond the roughly seventy cycles the sequence needs.
  initial begin
    #40000;
    n_mismatch++;
    end_sim;
  end
endmodule
